// ===== include/reload_timer_pkg.sv
// Shared constants and types for the reloadable timer
package reload_timer_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT  = 8'h04;
  localparam logic [7:0] ADDR_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // ==========================================================
  // Modes and control layout
  typedef enum logic [1:0] {
    MODE_ONESHOT = 2'h0,
    MODE_CONT    = 2'h1,
    MODE_PIN     = 2'h2,
    MODE_CMP     = 2'h3
  } mode_e;

  // Control word, bit 7 down to bit 0
  typedef struct packed {
    logic       out_en;
    logic       output_polarity_bit;
    logic [2:0] prescale;
    mode_e      mode;
    logic       enable;
  } ctrl_s;

  // Status word, bit 2 down to bit 0
  typedef struct packed {
    logic out_level;
    logic in_level;
    logic running;
  } status_s;

  // Bus data phase bookkeeping
  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] addr;
  } dphase_s;

  // ==========================================================
  // Reset values and count constants
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [15:0] RELOAD_RST    = 16'h0000;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_TOP     = 16'hFFFF;
  localparam logic [6:0]  PRE_RST       = 7'h00;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;

endpackage

// ===== rtl/reload_timer.sv
// Reloadable 16-bit timer with AHB-Lite register slave
//
// Behaviour
// - One-shot: count to reload, interrupt, 0001h, stop
// - One-shot: output inverts for one cycle
// - One-shot period set by reload, start, prescale
// - Continuous: reload gives interrupt, 0001h, keeps running
// - Repeating modes toggle output at each reload
// - Start count only for first pass
// - Continuous period is reload times 2^prescale clocks
// - Pin counter counts polarity-selected pin edges
// - Counter modes bypass the prescaler
// - Pin counter reload: interrupt, 0001h, continue
// - Edge select also sets initial output level
// - Comparator counter counts selected comparator edges
// - Comparator counter reload: interrupt, 0001h, continue
// - Count value readable by software
// - Count wraps FFFFh to 0000h
// - Prescaler divides by 1 to 128
`timescale 1ns/1ns
`default_nettype none

module reload_timer (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic      [1:0]  HRESP,
  // Counted inputs, asynchronous
  input  wire logic        TMR_IN,
  input  wire logic        CMP_OUT,
  // Timer output pin and event
  output logic             TMR_OUT,
  output logic             TMR_OUT_OE,
  output logic             TMR_IRQ
);

  // ==========================================================
  // Bus slave
  reload_timer_pkg::dphase_s dph_q;
  reload_timer_pkg::dphase_s dph_d;
  logic                      rd_done_q;
  logic                      rd_done_d;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;
  logic                      addr_ok;
  logic                      wr_ctrl;
  logic                      wr_count;
  logic                      wr_reload;

  // Timer state
  reload_timer_pkg::ctrl_s   ctrl_q;
  reload_timer_pkg::ctrl_s   ctrl_d;
  logic [15:0]               count_q;
  logic [15:0]               count_d;
  logic [15:0]               reload_q;
  logic [15:0]               reload_d;
  logic [6:0]                pre_q;
  logic [6:0]                pre_d;
  logic                      tout_q;
  logic                      tout_d;
  logic                      out_q;
  logic                      out_d;
  logic                      irq_q;
  logic                      irq_d;
  logic                      pulse_d;

  // Input synchronisers and edge detect
  logic                      pin_s1_q;
  logic                      pin_s2_q;
  logic                      cmp_s1_q;
  logic                      cmp_s2_q;
  logic                      prev_q;
  logic                      sel_in;
  logic                      edge_det;

  // Internal timing terms
  logic                      ext_mode;
  logic [6:0]                pre_mask;
  logic                      pre_tick;
  logic                      tick;
  logic                      reload_hit;
  reload_timer_pkg::status_s status;

  // ==========================================================
  // Address phase and data phase tracking
  assign addr_ok = HSEL && HTRANS[1] && HREADY;

  always_comb begin
    dph_d = dph_q;
    if (HREADY) begin
      dph_d.read  = addr_ok && !HWRITE;
      dph_d.write = addr_ok && HWRITE;
      dph_d.addr  = HADDR[7:0];
    end
    // Reads take one wait state so read data comes from a flip-flop
    rd_done_d = dph_q.read && !rd_done_q;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      dph_q     <= '0;
      rd_done_q <= 1'b0;
    end else begin
      dph_q     <= dph_d;
      rd_done_q <= rd_done_d;
    end
  end

  assign HREADYOUT = !(dph_q.read && !rd_done_q);
  assign HRESP     = reload_timer_pkg::HRESP_OKAY;
  assign HRDATA    = rdata_q;

  assign wr_ctrl   = dph_q.write && (dph_q.addr == reload_timer_pkg::ADDR_CTRL);
  assign wr_count  = dph_q.write && (dph_q.addr == reload_timer_pkg::ADDR_COUNT);
  assign wr_reload = dph_q.write && (dph_q.addr == reload_timer_pkg::ADDR_RELOAD);

  assign status.out_level = out_q;
  assign status.in_level  = sel_in;
  assign status.running   = ctrl_q.enable;

  // Read data, unmapped addresses read as zero
  always_comb begin
    rdata_d = rdata_q;
    if (dph_q.read && !rd_done_q) begin
      unique case (dph_q.addr)
        reload_timer_pkg::ADDR_CTRL:   rdata_d = {24'h000000, ctrl_q};
        reload_timer_pkg::ADDR_COUNT:  rdata_d = {16'h0000, count_q};
        reload_timer_pkg::ADDR_RELOAD: rdata_d = {16'h0000, reload_q};
        reload_timer_pkg::ADDR_STATUS: rdata_d = {29'h00000000, status};
        default:                       rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Input synchronisers, selected input and edge detect
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      prev_q   <= 1'b0;
    end else begin
      pin_s1_q <= TMR_IN;
      pin_s2_q <= pin_s1_q;
      cmp_s1_q <= CMP_OUT;
      cmp_s2_q <= cmp_s1_q;
      prev_q   <= sel_in;
    end
  end

  assign sel_in = (ctrl_q.mode == reload_timer_pkg::MODE_CMP) ? cmp_s2_q : pin_s2_q;

  // Polarity high counts rising edges, low counts falling edges
  assign edge_det = ctrl_q.output_polarity_bit ? (sel_in && !prev_q)
                                               : (!sel_in && prev_q);

  // ==========================================================
  // Prescaler and tick selection
  assign ext_mode = (ctrl_q.mode == reload_timer_pkg::MODE_PIN) ||
                    (ctrl_q.mode == reload_timer_pkg::MODE_CMP);
  assign pre_mask = 7'((8'h01 << ctrl_q.prescale) - 8'h01);
  assign pre_tick = (pre_q & pre_mask) == pre_mask;

  always_comb begin
    pre_d = reload_timer_pkg::PRE_RST;
    if (ctrl_q.enable && !ext_mode && !pre_tick) begin
      pre_d = pre_q + 7'h01;
    end
  end

  // Edges bypass the prescaler in both counter modes
  assign tick       = ctrl_q.enable && (ext_mode ? edge_det : pre_tick);
  assign reload_hit = tick && (count_q == reload_q);

  // ==========================================================
  // Counter, control and output next state
  always_comb begin
    ctrl_d   = ctrl_q;
    count_d  = count_q;
    reload_d = reload_q;
    tout_d   = tout_q;
    irq_d    = 1'b0;
    pulse_d  = 1'b0;
    if (reload_hit) begin
      count_d = reload_timer_pkg::COUNT_RESTART;
      irq_d   = 1'b1;
      if (ctrl_q.mode == reload_timer_pkg::MODE_ONESHOT) begin
        ctrl_d.enable = 1'b0;
        pulse_d       = 1'b1;
      end else begin
        tout_d = !tout_q;
      end
    end else if (tick) begin
      count_d = count_q + 16'h0001;
    end
    // Idle timer holds the output at the programmed start level
    if (!ctrl_q.enable) begin
      tout_d = ctrl_q.output_polarity_bit;
    end
    // Software writes take priority over the counter
    if (wr_ctrl) begin
      ctrl_d = reload_timer_pkg::ctrl_s'(HWDATA[7:0]);
    end
    if (wr_count) begin
      count_d = HWDATA[15:0];
    end
    if (wr_reload) begin
      reload_d = HWDATA[15:0];
    end
    out_d = pulse_d ? !tout_q : tout_d;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl_q   <= reload_timer_pkg::ctrl_s'(reload_timer_pkg::CTRL_RST);
      count_q  <= reload_timer_pkg::COUNT_RST;
      reload_q <= reload_timer_pkg::RELOAD_RST;
      pre_q    <= reload_timer_pkg::PRE_RST;
      tout_q   <= 1'b0;
      out_q    <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      count_q  <= count_d;
      reload_q <= reload_d;
      pre_q    <= pre_d;
      tout_q   <= tout_d;
      out_q    <= out_d;
      irq_q    <= irq_d;
    end
  end

  assign TMR_OUT    = out_q;
  assign TMR_OUT_OE = ctrl_q.out_en;
  assign TMR_IRQ    = irq_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  logic oneshot_mode;
  assign oneshot_mode = (ctrl_q.mode == reload_timer_pkg::MODE_ONESHOT);

  sequence s_inverted;
    TMR_OUT != tout_q;
  endsequence

  sequence s_restored;
    TMR_OUT == tout_q;
  endsequence

  property p_oneshot_stop;
    reload_hit && oneshot_mode && !dph_q.write
      |=> !ctrl_q.enable && (count_q == reload_timer_pkg::COUNT_RESTART) && TMR_IRQ;
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop)
    else $error("one-shot did not stop at reload");

  property p_oneshot_pulse;
    reload_hit && oneshot_mode && !dph_q.write |=> s_inverted ##1 s_restored;
  endproperty
  a_oneshot_pulse: assert property (p_oneshot_pulse)
    else $error("one-shot output pulse not one cycle");

  property p_repeat_keep;
    reload_hit && !oneshot_mode && !dph_q.write
      |=> ctrl_q.enable && (count_q == reload_timer_pkg::COUNT_RESTART);
  endproperty
  a_repeat_keep: assert property (p_repeat_keep)
    else $error("repeating mode stopped or did not restart at 0001h");

  property p_toggle;
    reload_hit && !oneshot_mode && !dph_q.write |=> tout_q != $past(tout_q);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("output did not toggle at reload");

  property p_edge_direct;
    ctrl_q.enable && ext_mode && edge_det && !reload_hit && !dph_q.write
      |=> count_q == 16'($past(count_q) + 16'h0001);
  endproperty
  a_edge_direct: assert property (p_edge_direct)
    else $error("counter mode edge did not add one");

  property p_edge_single;
    edge_det |=> !edge_det;
  endproperty
  a_edge_single: assert property (p_edge_single)
    else $error("one input edge gave two counts");

  property p_wrap;
    tick && (count_q == reload_timer_pkg::COUNT_TOP) && !reload_hit && !dph_q.write
      |=> count_q == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count did not wrap to zero");

  property p_irq_cause;
    TMR_IRQ |-> $past(reload_hit);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without reload");

  property p_prescale_gap;
    tick && !ext_mode && (ctrl_q.prescale != 3'h0) && !dph_q.write |=> !tick;
  endproperty
  a_prescale_gap: assert property (p_prescale_gap)
    else $error("prescaled ticks back to back");

  property p_read_wait;
    dph_q.read && !rd_done_q |-> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read data phase not two cycles");

endmodule // reload_timer

`default_nettype wire

// ===== verification/edge_source.sv
// Behavioural source for the counted pin and comparator lines
`timescale 1ns/1ns
`default_nettype none

module edge_source (
  // Clock
  input  wire logic clk,
  // Counted lines
  output logic      tmr_in,
  output logic      cmp_out
);
  initial begin
    tmr_in = 1'b0;
    cmp_out = 1'b0;
  end

  // ==========================================================
  // Transitions, each level held three clocks
  task automatic toggle(input int n, input logic use_cmp);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (use_cmp) cmp_out <= ~cmp_out;
      else tmr_in <= ~tmr_in;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // edge_source

`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the reloadable timer
`timescale 1ns/1ns
`default_nettype none

module tb;
  // ==========================================================
  // Signals
  logic        core_clk;
  logic        sys_rst;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [1:0]  hresp;
  logic        tmr_in;
  logic        cmp_out;
  logic        tmr_out;
  logic        tmr_out_oe;
  logic        tmr_irq;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cycles = 0;

  reload_timer reload_timer_inst (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .TMR_IN(tmr_in), .CMP_OUT(cmp_out),
    .TMR_OUT(tmr_out), .TMR_OUT_OE(tmr_out_oe), .TMR_IRQ(tmr_irq));

  edge_source edge_source_inst (.clk(core_clk), .tmr_in(tmr_in), .cmp_out(cmp_out));

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  // ==========================================================
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Ready sampled at the rising edge, read data taken at that edge
  task automatic wait_ready();
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (tmr_irq !== 1'b1 && n < 1000);
  endtask

  task automatic setup(input logic [7:0] ctl, input logic [15:0] start, input logic [15:0] top);
    bus(1'b1, reload_timer_pkg::ADDR_CTRL, {24'h0, ctl});
    bus(1'b1, reload_timer_pkg::ADDR_COUNT, {16'h0, start});
    check({31'h0, tmr_out}, {31'h0, ctl[6]}, "idle output level");
    bus(1'b1, reload_timer_pkg::ADDR_RELOAD, {16'h0, top});
    bus(1'b1, reload_timer_pkg::ADDR_CTRL, {24'h0, ctl | 8'h01});
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    bus(1'b0, reload_timer_pkg::ADDR_COUNT, 32'h0);
    check(rd, {16'h0, reload_timer_pkg::COUNT_RST}, "count reset");
    bus(1'b0, reload_timer_pkg::ADDR_RELOAD, 32'h0);
    check(rd, {16'h0, reload_timer_pkg::RELOAD_RST}, "reload reset");
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0, "unmapped read");
    bus(1'b0, reload_timer_pkg::ADDR_CTRL, 32'h0);
    check(rd, {24'h0, reload_timer_pkg::CTRL_RST}, "ctrl reset");
    check({28'h0, tmr_out, tmr_out_oe, hresp}, 32'h0, "pins at reset");
    $display("test_reset done");
  endtask

  task automatic test_oneshot();
    int c[2];
    int n;
    for (int i = 0; i < 2; i++) begin
      setup(8'h80, i ? 16'h0003 : 16'h0001, 16'h0008);
      wait_irq(c[i]);
      check({31'h0, tmr_out}, 32'h1, "one-shot pulse");
      @(negedge core_clk);
      check({31'h0, tmr_out}, 32'h0, "one-shot pulse end");
      bus(1'b0, reload_timer_pkg::ADDR_COUNT, 32'h0);
      check(rd, 32'h1, "one-shot restart count");
      bus(1'b0, reload_timer_pkg::ADDR_CTRL, 32'h0);
      check(rd, 32'h80, "one-shot self disable");
    end
    // Lasting change: start level low, polarity flipped once running
    setup(8'h80, 16'h0001, 16'h0008);
    bus(1'b1, reload_timer_pkg::ADDR_CTRL, 32'h000000C1);
    check({31'h0, tmr_out}, 32'h0, "start level kept");
    wait_irq(n);
    repeat (3) @(negedge core_clk);
    check({31'h0, tmr_out}, 32'h1, "lasting level change");
    check({31'h0, tmr_out_oe}, 32'h1, "output enable");
    check(32'(c[0] - c[1]), 32'h2, "one-shot length");
    $display("test_oneshot done");
  endtask

  task automatic test_cont();
    logic lvl;
    int   n;
    for (int p = 0; p < 2; p++) begin
      setup(p ? 8'hBA : 8'h92, 16'h0002, 16'h0003);
      wait_irq(n);
      lvl = tmr_out;
      for (int i = 0; i < 2; i++) begin
        wait_irq(n);
        check(32'(n), p ? 32'h180 : 32'h0C, "continuous period");
        check({31'h0, tmr_out}, {31'h0, ~lvl}, "continuous toggle");
        lvl = tmr_out;
      end
    end
    bus(1'b0, reload_timer_pkg::ADDR_STATUS, 32'h0);
    check({30'h0, rd[1:0]}, 32'h1, "status running, input low");
    bus(1'b1, reload_timer_pkg::ADDR_CTRL, 32'h0);
    $display("test_cont done");
  endtask

  task automatic test_pin();
    setup(8'hC4, 16'h0001, 16'h0005);
    edge_source_inst.toggle(5, 1'b0);
    bus(1'b0, reload_timer_pkg::ADDR_COUNT, 32'h0);
    check(rd, 32'h4, "rising edges counted");
    edge_source_inst.toggle(5, 1'b0);
    bus(1'b0, reload_timer_pkg::ADDR_COUNT, 32'h0);
    check(rd, 32'h1, "pin counter reload");
    check({31'h0, tmr_out}, 32'h0, "pin counter toggle");
    $display("test_pin done");
  endtask

  task automatic test_cmp();
    setup(8'h86, 16'hFFFE, 16'h0005);
    edge_source_inst.toggle(4, 1'b1);
    bus(1'b0, reload_timer_pkg::ADDR_COUNT, 32'h0);
    check(rd, 32'h0, "falling edges wrap");
    edge_source_inst.toggle(12, 1'b1);
    bus(1'b0, reload_timer_pkg::ADDR_COUNT, 32'h0);
    check(rd, 32'h1, "comparator reload");
    check({31'h0, tmr_out}, 32'h1, "comparator toggle");
    $display("test_cmp done");
  endtask

  // ==========================================================
  // Verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    test_reset();
    test_oneshot();
    test_cont();
    test_pin();
    test_cmp();
    give_verdict();
  end
endmodule // tb

`default_nettype wire
